// [src/dpds_defs.vh]
// Constants of the drive process data image and status word.
// Assumes byte addressed cyclic images of at most sixteen bytes.
`ifndef DPDS_DEFS_VH
`define DPDS_DEFS_VH

// ----------------------------------------------------------------
// Image byte offsets, little-endian fields
// ----------------------------------------------------------------
`define DPDS_OFS_CTRL        4'h0
`define DPDS_OFS_SPARE       4'h2
`define DPDS_OFS_TARGET      4'h4
`define DPDS_OFS_PID         4'h8
`define DPDS_OFS_PSUB        4'ha
`define DPDS_OFS_PVAL        4'hc
`define DPDS_OFS_STATUS      4'h0
`define DPDS_OFS_SPEED       4'h2
`define DPDS_OFS_POS         4'h4
`define DPDS_LAST_LONG       4'hf
`define DPDS_LAST_SHORT      4'h7

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define DPDS_CB_MAN_UP       0
`define DPDS_CB_MAN_DN       1
`define DPDS_CB_TAKE         2
`define DPDS_CB_RELEASE      4
`define DPDS_CB_RSVD_MASK    16'hffe8

// ----------------------------------------------------------------
// Status word fields and reset value
// ----------------------------------------------------------------
`define DPDS_SB_REACHED      0
`define DPDS_SB_FOLLOW       1
`define DPDS_SB_SUPPLY       4
`define DPDS_SB_ABORT        5
`define DPDS_SB_RUNNING      6
`define DPDS_SB_OVERTEMP     7
`define DPDS_SB_LOOP         8
`define DPDS_SB_ERROR        9
`define DPDS_STATUS_RST      16'h0100

// ----------------------------------------------------------------
// Analogue limits: voltage in 0.1 V steps, temperature in deg C
// ----------------------------------------------------------------
`define DPDS_VOLT_MAX        16'h012c
`define DPDS_TEMP_HYST       16'h0005

`endif

// [src/dpds_out_image.v]
// Byte store of the output image written by the network scanner.
// Assumes byte writes arrive on the drive clock from the link logic.
`timescale 1ns/1ps
`include "dpds_defs.vh"

module dpds_out_image (
    // Clock, reset, enable
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_ce,
    // Byte write port
    input  wire        i_wr,
    input  wire [3:0]  i_addr,
    input  wire [7:0]  i_data,
    input  wire        i_long,
    // Assembled fields
    output wire [15:0] o_ctrl_word,
    output wire [31:0] o_target_value,
    output wire [15:0] o_param_identifier_word,
    output wire [15:0] o_param_subindex_word,
    output wire [31:0] o_param_value_dword
);

    reg [7:0] img [0:15];
    integer   k;

    // ------------------------------------------------------------
    // Byte store
    // ------------------------------------------------------------
    // Short image drops writes past byte 7; parameter bytes stored
    // earlier stay on the parameter outputs
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (k = 0; k < 16; k = k + 1) begin
                img[k] <= 8'h00;
            end
        end else if (i_ce && i_wr &&
                     (i_long || i_addr <= `DPDS_LAST_SHORT)) begin
            img[i_addr] <= i_data;
        end
    end

    // ------------------------------------------------------------
    // Field assembly, lowest byte least significant
    // ------------------------------------------------------------
    assign o_ctrl_word    = {img[1], img[0]};
    assign o_target_value = {img[7], img[6], img[5], img[4]};
    assign o_param_identifier_word = {img[9], img[8]};
    assign o_param_subindex_word   = {img[11], img[10]};
    assign o_param_value_dword =
        {img[15], img[14], img[13], img[12]};
endmodule // dpds_out_image

// [src/dpds_run_cmd.v]
// Decodes the control word into run commands and tracks the run.
// Assumes the motion logic reports the end of a positioning run.
`timescale 1ns/1ps
`include "dpds_defs.vh"

module dpds_run_cmd (
    // Clock, reset, enable
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_ce,
    // Control and drive state
    input  wire [15:0] i_ctrl_word,
    input  wire        i_error,
    input  wire        i_run_done,
    // Command pulses and run state
    output reg         o_take_target,
    output reg         o_pos_start,
    output reg         o_man_start,
    output reg         o_abort,
    output reg         o_man_up,
    output wire        o_run_pos,
    output wire        o_run_man
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_POS  = 3'b010;
    localparam [2:0] ST_MAN  = 3'b100;
    reg  [2:0] state;
    reg        prev_take;
    wire       release_on;
    wire       man_up;
    wire       man_dn;
    wire       take;
    wire       invalid;
    wire       take_edge;

    assign release_on = i_ctrl_word[`DPDS_CB_RELEASE];
    assign man_up     = i_ctrl_word[`DPDS_CB_MAN_UP];
    assign man_dn     = i_ctrl_word[`DPDS_CB_MAN_DN];
    assign take       = i_ctrl_word[`DPDS_CB_TAKE];
    // Reserved bits set or both manual directions is a bad combination
    assign invalid    = (|(i_ctrl_word & `DPDS_CB_RSVD_MASK)) ||
                        (man_up && man_dn);
    assign take_edge  = take && !prev_take;
    assign o_run_pos  = (state == ST_POS);
    assign o_run_man  = (state == ST_MAN);

    // ------------------------------------------------------------
    // Run state machine
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state         <= ST_IDLE;
            prev_take     <= 1'b0;
            o_take_target <= 1'b0;
            o_pos_start   <= 1'b0;
            o_man_start   <= 1'b0;
            o_abort       <= 1'b0;
            o_man_up      <= 1'b0;
        end else if (i_ce) begin
            prev_take     <= take;
            o_take_target <= take_edge && !invalid;
            o_pos_start   <= 1'b0;
            o_man_start   <= 1'b0;
            o_abort       <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Error or missing release refuses any run
                    if (release_on && !invalid && !i_error) begin
                        if (man_up || man_dn) begin
                            state       <= ST_MAN;
                            o_man_start <= 1'b1;
                            o_man_up    <= man_up;
                        end else if (take_edge) begin
                            state       <= ST_POS;
                            o_pos_start <= 1'b1;
                        end
                    end
                end
                ST_POS: begin
                    if (!release_on || invalid) begin
                        state   <= ST_IDLE;
                        o_abort <= 1'b1;
                    end else if (i_run_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_MAN: begin
                    if (!release_on || invalid) begin
                        state   <= ST_IDLE;
                        o_abort <= 1'b1;
                    end else if (!man_up && !man_dn) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // dpds_run_cmd

// [src/dpds_top.v]
// Cyclic process data image of a positioning drive and its status
// word. Assumes the motion, supply and temperature inputs come from
// logic on the same drive clock; the scanner link writes the output
// image byte by byte and reads the input image byte by byte.
`timescale 1ns/1ps
`include "dpds_defs.vh"

// What this block does
// - Output image: control 0-1, spare 2-3, target 4-7, param fields 8-15.
// - Input image: status 0-1, speed 2-3, position 4-7, param fields after.
// - Without parameter channel both images shrink from 16 to 8 bytes.
// - Bit 0 set on positioning target reached or back inside window.
// - Bit 0 cleared by far target, manual run, bad target, displacement.
// - Bit 1 set on following error while running; cleared by new run.
// - Bit 4 high while supply above limit and below 30 V.
// - Bit 5 set when run aborted by release or bad control word.
// - Bit 6 follows shaft rotation.
// - Bit 7 set above temperature limit, cleared 5 degrees below it.
// - Bit 8 set at reset, on run against loop, or zero loop.
// - Bit 8 cleared only by positioning reached in loop direction.
// - Bit 9 set on position calculation fault; blocks every run.
// - Bit 9 clears only through reset.
// - Runs need the release bit; dropping it aborts and sets bit 5.
module dpds_top (
    // Clock, reset, enable
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_ce,
    // Length options, high selects the parameter channel
    input  wire        i_output_length_option,
    input  wire        i_input_length_option,
    // Output image byte writes from the link
    input  wire        i_out_wr,
    input  wire [3:0]  i_out_addr,
    input  wire [7:0]  i_out_data,
    // Input image byte reads from the link
    input  wire [3:0]  i_in_addr,
    output reg  [7:0]  o_in_data,
    // Drive parameters
    input  wire [31:0] i_pos_window,
    input  wire [31:0] i_follow_limit,
    input  wire [15:0] i_loop_length,
    input  wire        i_loop_dir_up,
    input  wire [15:0] i_umot_limit,
    input  wire [15:0] i_temp_limit,
    // Motion and sensor state
    input  wire [31:0] i_actual_position,
    input  wire [31:0] i_set_position,
    input  wire [15:0] i_actual_speed,
    input  wire [15:0] i_motor_voltage,
    input  wire [15:0] i_temperature,
    input  wire        i_rotating,
    input  wire        i_braking,
    input  wire        i_pos_reached,
    input  wire        i_pos_ended,
    input  wire        i_target_invalid,
    input  wire        i_displaced,
    input  wire        i_calc_fault,
    // Parameter channel response
    input  wire [15:0] i_param_identifier_word,
    input  wire [15:0] i_param_subindex_word,
    input  wire [31:0] i_param_value_dword,
    // Parameter channel request
    output wire [15:0] o_param_identifier_word,
    output wire [15:0] o_param_subindex_word,
    output wire [31:0] o_param_value_dword,
    // Commands to the motion logic
    output reg  [31:0] o_target_value,
    output wire        o_pos_start,
    output wire        o_man_start,
    output wire        o_man_up,
    output wire        o_abort,
    // Status
    output reg  [15:0] o_status_word
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Distance between two signed positions, used for window and
    // following error checks
    function [31:0] dpds_dist;
        input [31:0] a;
        input [31:0] b;
        reg   [31:0] d;
        begin
            d = a - b;
            dpds_dist = d[31] ? (~d + 32'h0000_0001) : d;
        end
    endfunction

    // Signed compare, high when a lies above b
    function dpds_above;
        input [31:0] a;
        input [31:0] b;
        begin
            dpds_above = $signed(a) > $signed(b);
        end
    endfunction

    wire [15:0] ctrl_word;
    wire [31:0] img_target;
    wire        take_target;
    wire        run_pos;
    wire        run_man;
    wire        new_run;
    wire        err_flag;
    reg         pos_dir_ok;
    reg         was_displaced;
    reg         run_pos_d;
    reg         man_up_run;
    reg  [15:0] next_status;
    reg         run_up;
    reg  [15:0] temp_low;

    assign err_flag = o_status_word[`DPDS_SB_ERROR];
    assign new_run  = o_pos_start || o_man_start;

    // ------------------------------------------------------------
    // Output image and run command decode
    // ------------------------------------------------------------
    dpds_out_image u_out_image (
        .i_clk                   (i_clk),
        .i_nrst                  (i_nrst),
        .i_ce                    (i_ce),
        .i_wr                    (i_out_wr),
        .i_addr                  (i_out_addr),
        .i_data                  (i_out_data),
        .i_long                  (i_output_length_option),
        .o_ctrl_word             (ctrl_word),
        .o_target_value          (img_target),
        .o_param_identifier_word (o_param_identifier_word),
        .o_param_subindex_word   (o_param_subindex_word),
        .o_param_value_dword     (o_param_value_dword)
    );

    dpds_run_cmd u_run_cmd (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_ce          (i_ce),
        .i_ctrl_word   (ctrl_word),
        .i_error       (err_flag),
        .i_run_done    (i_pos_reached || i_pos_ended),
        .o_take_target (take_target),
        .o_pos_start   (o_pos_start),
        .o_man_start   (o_man_start),
        .o_abort       (o_abort),
        .o_man_up      (o_man_up),
        .o_run_pos     (run_pos),
        .o_run_man     (run_man)
    );

    // ------------------------------------------------------------
    // Target latch and run direction bookkeeping
    // ------------------------------------------------------------
    // The target is held apart from the image so a scanner rewrite
    // reaches it only on a take edge, which latches even during a run
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_target_value <= 32'h0000_0000;
            pos_dir_ok     <= 1'b0;
            was_displaced  <= 1'b0;
            run_pos_d      <= 1'b0;
            man_up_run     <= 1'b0;
        end else if (i_ce) begin
            run_pos_d <= run_pos;
            if (take_target) begin
                o_target_value <= img_target;
            end
            if (o_pos_start) begin
                pos_dir_ok <= (i_loop_length != 16'h0000) &&
                    (dpds_above(img_target, i_actual_position)
                     == i_loop_dir_up);
            end
            if (o_man_start) begin
                man_up_run <= o_man_up;
            end
            // Remember a displacement until back in the window or a new run starts
            if (i_displaced && !i_rotating) begin
                was_displaced <= 1'b1;
            end else if (new_run || dpds_dist(i_actual_position,
                         o_target_value) <= i_pos_window) begin
                was_displaced <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Status word next value; each set term is applied after its
    // clear term so a simultaneous event is never lost
    // ------------------------------------------------------------
    always @* begin
        next_status = o_status_word;
        run_up      = o_man_start ? o_man_up : man_up_run;
        temp_low    = i_temp_limit - `DPDS_TEMP_HYST;
        // Target reached
        if ((take_target && dpds_dist(img_target, i_actual_position)
             > i_pos_window) || o_man_start || i_target_invalid ||
            (i_displaced && !i_rotating)) begin
            next_status[`DPDS_SB_REACHED] = 1'b0;
        end
        if ((run_pos_d && i_pos_reached) ||
            (was_displaced && !i_displaced && dpds_dist(
             i_actual_position, o_target_value) <= i_pos_window)) begin
            next_status[`DPDS_SB_REACHED] = 1'b1;
        end
        // Following error
        if (new_run) begin
            next_status[`DPDS_SB_FOLLOW] = 1'b0;
        end
        if ((run_pos || run_man) && !i_braking &&
            dpds_dist(i_set_position, i_actual_position)
            > i_follow_limit) begin
            next_status[`DPDS_SB_FOLLOW] = 1'b1;
        end
        // Motor supply inside its corridor
        next_status[`DPDS_SB_SUPPLY] =
            (i_motor_voltage > i_umot_limit) &&
            (i_motor_voltage < `DPDS_VOLT_MAX);
        // Run aborted
        if (new_run) begin
            next_status[`DPDS_SB_ABORT] = 1'b0;
        end
        if (o_abort) begin
            next_status[`DPDS_SB_ABORT] = 1'b1;
        end
        // Running
        next_status[`DPDS_SB_RUNNING] = i_rotating;
        // Overtemperature with hysteresis
        if (i_temperature <= temp_low) begin
            next_status[`DPDS_SB_OVERTEMP] = 1'b0;
        end
        if (i_temperature > i_temp_limit) begin
            next_status[`DPDS_SB_OVERTEMP] = 1'b1;
        end
        // Loop direction: only a reached positioning run clears it
        if (run_pos_d && i_pos_reached && pos_dir_ok) begin
            next_status[`DPDS_SB_LOOP] = 1'b0;
        end
        if ((o_pos_start && ((i_loop_length == 16'h0000) ||
             (dpds_above(img_target, i_actual_position)
              != i_loop_dir_up))) ||
            (o_man_start && ((i_loop_length == 16'h0000) ||
             (run_up != i_loop_dir_up)))) begin
            next_status[`DPDS_SB_LOOP] = 1'b1;
        end
        // Error is sticky; nothing but reset clears it
        if (i_calc_fault) begin
            next_status[`DPDS_SB_ERROR] = 1'b1;
        end
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status_word <= `DPDS_STATUS_RST;
        end else if (i_ce) begin
            o_status_word <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Input image byte read
    // ------------------------------------------------------------
    // Short image reads zero past byte 7
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_in_data <= 8'h00;
        end else if (i_ce) begin
            if (!i_input_length_option &&
                i_in_addr > `DPDS_LAST_SHORT) begin
                o_in_data <= 8'h00;
            end else begin
                case (i_in_addr)
                    4'h0: o_in_data <= o_status_word[7:0];
                    4'h1: o_in_data <= o_status_word[15:8];
                    4'h2: o_in_data <= i_actual_speed[7:0];
                    4'h3: o_in_data <= i_actual_speed[15:8];
                    4'h4: o_in_data <= i_actual_position[7:0];
                    4'h5: o_in_data <= i_actual_position[15:8];
                    4'h6: o_in_data <= i_actual_position[23:16];
                    4'h7: o_in_data <= i_actual_position[31:24];
                    4'h8: o_in_data <= i_param_identifier_word[7:0];
                    4'h9: o_in_data <= i_param_identifier_word[15:8];
                    4'ha: o_in_data <= i_param_subindex_word[7:0];
                    4'hb: o_in_data <= i_param_subindex_word[15:8];
                    4'hc: o_in_data <= i_param_value_dword[7:0];
                    4'hd: o_in_data <= i_param_value_dword[15:8];
                    4'he: o_in_data <= i_param_value_dword[23:16];
                    4'hf: o_in_data <= i_param_value_dword[31:24];
                    default: o_in_data <= 8'h00;
                endcase
            end
        end
    end

endmodule // dpds_top

// [tb/dpds_chk_sva.sv]
// Checker: status bits and command pulses of the process data block.
// Assumes one drive clock and an active low asynchronous reset.
`timescale 1ns/1ps
module dpds_chk (
    // Watched ports
    input wire        i_clk,
    input wire        i_nrst,
    input wire        i_ce,
    input wire        i_input_length_option,
    input wire [3:0]  i_in_addr,
    input wire [7:0]  o_in_data,
    input wire [15:0] i_temp_limit,
    input wire [15:0] i_temperature,
    input wire        i_rotating,
    input wire        o_pos_start,
    input wire        o_man_start,
    input wire        o_abort,
    input wire [15:0] o_status_word
);
    // --------
    // Helpers
    // --------
    wire hot   = i_temperature > i_temp_limit;
    wire warm  = i_temperature + 16'h0005 > i_temp_limit;
    wire start = o_pos_start || o_man_start;
    reg  live;  // Last edge ran; a frozen or reset edge makes no update
    always @(posedge i_clk or negedge i_nrst)
        if (!i_nrst)
            live <= 1'b0;
        else
            live <= i_ce;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // --------
    // Properties
    // --------
    property p_rst; $rose(i_nrst) |-> o_status_word == 16'h0100; endproperty
    property p_run; live |-> o_status_word[6] == $past(i_rotating); endproperty
    property p_hot; live && $past(hot) |-> o_status_word[7]; endproperty
    property p_hold; o_status_word[7] && warm && i_ce |=> o_status_word[7];
    endproperty
    property p_err; o_status_word[9] |=> o_status_word[9]; endproperty
    property p_ref; o_status_word[9] |=> !start; endproperty
    property p_abt; o_abort |=> o_status_word[5]; endproperty
    property p_new; start && !o_abort |=> !o_status_word[5]; endproperty
    property p_man; o_man_start |=> !o_status_word[0]; endproperty
    property p_short; !i_input_length_option && i_in_addr[3] && i_ce
        |=> o_in_data == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset status wrong");
    a_run: assert property (p_run) else $error("running bit wrong");
    a_hot: assert property (p_hot) else $error("overheat not set");
    a_hold: assert property (p_hold) else $error("overheat early");
    a_err: assert property (p_err) else $error("error bit dropped");
    a_ref: assert property (p_ref) else $error("run with error");
    a_abt: assert property (p_abt) else $error("abort bit missing");
    a_new: assert property (p_new) else $error("abort bit kept");
    a_man: assert property (p_man) else $error("reached bit kept");
    a_short: assert property (p_short) else $error("short read");
    c_pos: cover property (o_pos_start);
    c_man: cover property (o_man_start);
    c_abt: cover property (o_abort);
    c_err: cover property (o_status_word[9]);
endmodule // dpds_chk

bind dpds_top dpds_chk u_chk (.*);

// [tb/dpds_scan.sv]
// Scanner model: byte writes of the output image, byte reads of the
// input image. Assumes the block takes one byte per clock edge.
`timescale 1ns/1ps
module dpds_scan (
    // Clock and read data
    input  wire       i_clk,
    input  wire [7:0] i_rdata,
    // Image port, changed just after an edge
    output reg        o_wr = 1'b0,
    output reg  [3:0] o_wa = 4'h0,
    output reg  [7:0] o_wd = 8'h00,
    output reg  [3:0] o_ra = 4'h0,
    output reg        o_lo = 1'b1,
    output reg        o_li = 1'b1
);
    integer k;
    // Lowest byte first; idle data inverts so no stale byte lingers
    task wr(input [3:0] a, input [31:0] v, input integer n);
        begin
            for (k = 0; k < n; k = k + 1) begin
                @(posedge i_clk);
                o_wr <= 1'b1;
                o_wa <= a + k[3:0];
                o_wd <= v[8*k +: 8];
            end
            @(posedge i_clk);
            o_wr <= 1'b0;
            o_wd <= ~o_wd;
        end
    endtask
    // Each byte answers one edge after its address
    task rd(input [3:0] a, input integer n, output [31:0] v);
        begin
            v = 32'h0;
            for (k = 0; k < n; k = k + 1) begin
                @(posedge i_clk);
                o_ra <= a + k[3:0];
                @(posedge i_clk);
                #1 v[8*k +: 8] = i_rdata;
            end
            @(posedge i_clk);
        end
    endtask
endmodule // dpds_scan

// [tb/tb.sv]
// Bench: scanner model on the image port, integer model of status
// word and command pulses. Assumes a 25 MHz drive clock.
`timescale 1ns/1ps
module tb;
    // --------
    // Signals
    // --------
    reg         i_clk = 1'b0, i_nrst = 1'b0, i_rotating = 1'b0;
    reg         i_braking = 1'b0, i_pos_reached = 1'b0, i_pos_ended = 1'b0;
    reg         i_target_invalid = 1'b0, i_displaced = 1'b0;
    reg         i_calc_fault = 1'b0, i_ce = 1'b1;
    reg  [31:0] i_actual_position = 32'h0, i_set_position = 32'h0;
    reg  [31:0] i_follow_limit = 32'h20, i_param_value_dword = 32'h0;
    reg  [15:0] i_actual_speed = 16'h0, i_param_identifier_word = 16'h0;
    reg  [15:0] i_param_subindex_word = 16'h0, i_loop_length = 16'h10;
    reg  [15:0] i_motor_voltage = 16'h0, i_temperature = 16'h0;
    wire        i_out_wr, i_output_length_option, i_input_length_option;
    wire [3:0]  i_out_addr, i_in_addr;
    wire [7:0]  i_out_data, o_in_data;
    wire        o_pos_start, o_man_start, o_man_up, o_abort;
    wire [15:0] o_status_word, o_param_identifier_word;
    wire [15:0] o_param_subindex_word;
    wire [31:0] o_param_value_dword, o_target_value;
    integer     bad_count = 0, comparisons = 0, cyc = 0, i;
    integer     np = 0, nm = 0, na = 0, enp = 0, enm = 0, ena = 0;
    reg  [31:0] seed = 32'h1413b9d0, w, x;
    reg  [15:0] sm = 16'h0100;
    reg  [79:0] vt = {16'h00c8, 16'h012c, 16'h012b, 16'h00ba, 16'h00b9};
    reg  [47:0] tv = {16'h0041, 16'h0042, 16'h0047};
    dpds_scan scn (.i_clk, .i_rdata(o_in_data), .o_wr(i_out_wr),
        .o_wa(i_out_addr), .o_wd(i_out_data), .o_ra(i_in_addr),
        .o_lo(i_output_length_option), .o_li(i_input_length_option));
    dpds_top dut (.*, .i_pos_window(32'h10),
        .i_loop_dir_up(1'b1), .i_umot_limit(16'h00b9),
        .i_temp_limit(16'h0046));
    // --------
    // Clock, pulse counts, hang limit
    // --------
    initial forever #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        np = np + o_pos_start;
        nm = nm + o_man_start;
        na = na + o_abort;
        cyc = cyc + 1;
        if (cyc == 4000) begin
            bad_count = bad_count + 1;
            test_done;
        end
    end
    task tk(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    task chk(input [63:0] t, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0s exp %h got %h", t, e, g);
            end
        end
    endtask
    // Waits out status latency, compares the model
    task st;
        begin
            tk(3);
            #1 chk("status", sm, o_status_word);
            chk("pstart", enp, np);
            chk("mstart", enm, nm);
            chk("abort", ena, na);
            @(posedge i_clk);
        end
    endtask
    task cw(input [7:0] c);
        scn.wr(4'h0, c, 1);
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        tk(4);
        i_nrst <= 1'b1;
        st;
        w = $random(seed);
        scn.wr(4'h8, w, 4);
        i_actual_position <= w;
        scn.rd(4'h4, 4, x);
        chk("posimg", w, x);
        chk("pid", w[15:0], o_param_identifier_word);
        chk("psub", w[31:16], o_param_subindex_word);
        scn.rd(4'h0, 2, x);
        chk("stimg", 16'h0100, x);
        i_actual_position <= 32'h0;
        scn.o_lo <= 1'b0;
        scn.o_li <= 1'b0;
        scn.wr(4'h8, ~w, 2);
        scn.rd(4'h8, 2, x);
        chk("shrd", 0, x);
        chk("shwr", w[15:0], o_param_identifier_word);
        scn.o_lo <= 1'b1;
        scn.o_li <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            i_motor_voltage <= vt[16*i +: 16];
            sm[4] = (i != 0 && i != 3);
            st;
        end
        for (i = 0; i < 3; i = i + 1) begin
            i_temperature <= tv[16*i +: 16];
            sm[7] = (i < 2);
            st;
        end
        scn.wr(4'h4, 32'h100, 4);
        cw(8'h04);
        st;
        cw(8'h00);
        cw(8'h14);
        enp = 1;
        st;
        chk("target", 32'h100, o_target_value);
        i_rotating <= 1'b1;
        i_set_position <= 32'h80;
        sm = 16'h0152;
        st;
        i_rotating <= 1'b0;
        i_set_position <= 32'h100;
        i_actual_position <= 32'h100;
        i_pos_reached <= 1'b1;
        tk(1);
        i_pos_reached <= 1'b0;
        sm = 16'h0013;
        st;
        scn.wr(4'h4, 32'h300, 4);
        cw(8'h10);
        cw(8'h14);
        enp = 2;
        i_rotating <= 1'b1;
        sm = 16'h0050;
        st;
        cw(8'h00);
        ena = 1;
        i_rotating <= 1'b0;
        sm = 16'h0030;
        st;
        cw(8'h10);
        cw(8'h12);
        enm = 1;
        sm = 16'h0110;
        st;
        chk("mandir", 0, o_man_up);
        cw(8'h10);
        i_calc_fault <= 1'b1;
        tk(1);
        i_calc_fault <= 1'b0;
        sm = 16'h0310;
        st;
        cw(8'h14);
        st;
        i_nrst <= 1'b0;
        tk(2);
        i_nrst <= 1'b1;
        sm = 16'h0110;
        st;
        i_ce <= 1'b0;
        i_rotating <= 1'b1;
        st;
        test_done;
    end
endmodule // tb
